//--- src/lsd_pkg.sv
// Constants and register map of the line supervision debounce block
package lsd_pkg;
  // Geometry
  localparam int NUM_CH = 4; // Channels served
  localparam int NUM_PINS = 15; // Pin inputs passed through synchronisers
  // Pin vector layout
  localparam int PIN_LOOP = 0; // Loop-detect inputs, four bits
  localparam int PIN_AUX = 4; // Auxiliary detect inputs, four bits
  localparam int PIN_GK = 8; // Ground-key samples, four bits
  localparam int PIN_FS = 12; // Frame sync
  localparam int PIN_CS = 13; // Serial chip select, active low
  localparam int PIN_SCLK = 14; // Serial port clock
  // Timing
  localparam int FS_PERIOD_NS = 125000; // Frame sync period
  localparam int MS_NS = 1000000; // Debounce time unit
  localparam int FS_PER_MS = MS_NS / FS_PERIOD_NS; // Frames per millisecond
  localparam int CS_RESET_EDGES = 16; // Serial clock edges for CS reset
  localparam int GK_MAX = 6; // Top of the ground-key counter
  // Register byte addresses
  localparam logic [7:0] ADDR_RT_STATUS = 8'h00; // Status, no side effect
  localparam logic [7:0] ADDR_RT_CLEAR = 8'h04; // Status, read clears irq
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08; // Mask, write clears irq
  localparam logic [7:0] ADDR_CONFIG = 8'h0C; // Shared configuration
  localparam logic [7:0] ADDR_GK_PERIOD = 8'h10; // Per-channel GK codes
  localparam logic [7:0] ADDR_RAW_DET = 8'h14; // Undebounced detect bits
  localparam logic [7:0] ADDR_TX_ARM = 8'h18; // Transmit change arm bits
  localparam logic [7:0] ADDR_SOFT_RST = 8'h1C; // Any write resets
  // Config field positions
  localparam int CFG_LOOP_LSB = 0; // Loop debounce code, four bits
  localparam int CFG_OPEN_DRAIN = 4; // Interrupt driver type
  localparam int CFG_MUX_EN = 7; // Line multiplex enable
  // Reset values
  localparam logic [3:0] RST_LOOP_CODE = 4'h8; // 8 ms
  localparam logic [7:0] RST_MASK = 8'hFF; // All sources masked
  localparam logic RST_OPEN_DRAIN = 1'b1; // Open drain after reset
endpackage : lsd_pkg

//--- src/lsd_top.sv
// Debounce filters, status register and interrupt of four line channels
//
// Behaviour
// - Two filters per channel, second input muxed
// - Loop debounce code shared, counters per channel
// - Sample loop each frame; change restarts counter
// - Counter steps per ms; update at code
// - Ground-key counter 0..6, period 1..15 ms
// - High sample increments, low sample decrements
// - Six sets latch, zero clears, else hold
// - Period code zero bypasses the counter
// - Eight-bit status: loop and aux per channel
// - Status readable whatever channels are selected
// - Raw detect register gives undebounced bits
// - Interrupt on unmasked change or armed tx
// - Interrupt holds until cleared; driver selectable
// - Unmasked status bits freeze while pending
// - Clear by clearing read, mask write, reset
// - Difference at clear raises new interrupt
// - Mask register writable and readable
// - Reset by pin, command or long CS
// - Reset clears, masks all, selects open drain
// - Reset loop debounce time is 8 ms
// - Mux enable is config bit seven
//
// Notes
// Pins pass three flops.
// A level counts once the
// second and third agree.
// Frame sync rises give the
// frame tick; a divider
// turns frames into ms.
// Without frame sync only
// bypassed aux filters move.
// Loop filter samples each
// frame; a change restarts
// the channel counter.
// The counter stops at 15.
// Status copies the sample
// once count meets the code.
// Code zero: next frame.
// Aux filter steps once per
// period code in ms.
// Its counter rests at 0
// and 6; 6 sets, 0 clears.
// Code zero: bypass with a
// one-cycle lag.
// Mux enable swaps the aux
// pin for the ground-key.
// Status register: loop at
// bit 2c, aux at 2c+1.
// Unmasked bits freeze
// while an irq is pending.
// Masked bits keep tracking
// the live value.
// A clear that meets a
// difference sets again:
// set wins over clear.
// The host must treat the
// line as a level.
// APB never waits; read
// data is caught in setup.
// Unmapped addresses give
// an error and read zero.
// Soft reset keeps the
// synchronisers as they
// are, so pins need no
// resettle afterwards.
// Clock enable low freezes
// everything, APB too.
`timescale 1ns/1ps
module lsd_top #(
  parameter int FRAMES_PER_MS = lsd_pkg::FS_PER_MS // Frame ticks per ms
) (
  input wire logic I_CLK, // 20 MHz clock
  input wire logic I_RST_B, // Asynchronous reset, active low
  input wire logic I_CE, // Clock enable, freezes all state when low
  input wire logic [lsd_pkg::NUM_CH-1:0] I_LOOP_DET, // Loop-detect pins
  input wire logic [lsd_pkg::NUM_CH-1:0] I_AUX_DET, // Aux detect pins
  input wire logic [lsd_pkg::NUM_CH-1:0] I_GK_SAMPLE, // Ground-key samples
  input wire logic I_FS, // Frame sync pin
  input wire logic I_CS_B, // Serial chip select pin, active low
  input wire logic I_SCLK, // Serial port clock pin
  input wire logic [lsd_pkg::NUM_CH-1:0] I_TX_CHANGE, // Tx data changed
  input wire logic I_PSEL, // APB select
  input wire logic I_PENABLE, // APB enable
  input wire logic I_PWRITE, // APB direction
  input wire logic [7:0] I_PADDR, // APB byte address
  input wire logic [31:0] I_PWDATA, // APB write data
  output logic [31:0] O_PRDATA, // APB read data
  output logic O_PREADY, // APB ready
  output logic O_PSLVERR, // APB error on unmapped address
  output logic O_IRQ_B_O, // Interrupt pin level, active low
  output logic O_IRQ_B_OE // Interrupt pin drive enable
);
  import lsd_pkg::*;

  // Elaboration check on the frame divider
  if (FRAMES_PER_MS < 1 || FRAMES_PER_MS > 256) begin : g_bad_div
    $error("FRAMES_PER_MS must lie in 1..256");
  end

  // Whole state of the block
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1; // First synchroniser stage
    logic [NUM_PINS-1:0] sync2; // Second stage
    logic [NUM_PINS-1:0] sync3; // Third stage
    logic [NUM_PINS-1:0] stab; // Accepted pin levels
    logic [7:0] fs_div; // Frames within the current ms
    logic [NUM_CH-1:0] loop_smp; // Loop input at last frame
    logic [NUM_CH-1:0][3:0] loop_cnt; // Loop debounce counters
    logic [NUM_CH-1:0] loop_stat; // Debounced loop status
    logic [NUM_CH-1:0][3:0] gk_tmr; // Ground-key sample timers
    logic [NUM_CH-1:0][2:0] gk_cnt; // Up/down counters
    logic [NUM_CH-1:0] aux_stat; // Debounced aux status latches
    logic [7:0] rt; // Real-time status register
    logic [7:0] mask; // Interrupt mask, one masks
    logic pend; // Interrupt pending
    logic [3:0] loop_code; // Shared loop debounce code
    logic open_drain; // Interrupt driver type
    logic mux_en; // Line multiplex enable
    logic [NUM_CH-1:0][3:0] gk_code; // Ground-key period codes
    logic [NUM_CH-1:0] tx_arm; // Transmit change arm bits
    logic [4:0] cs_cnt; // Serial clock edges with CS low
    logic [31:0] prdata; // Read data
    logic pslverr; // Error answer
  } lsd_state_t;

  // Value taken on any reset
  function automatic lsd_state_t reset_state();
    lsd_state_t s;
    s = '0;
    s.mask = RST_MASK;
    s.open_drain = RST_OPEN_DRAIN;
    s.loop_code = RST_LOOP_CODE;
    return s;
  endfunction : reset_state

  // Address decode used by both the error answer and the side effects
  function automatic logic addr_mapped(input logic [7:0] a);
    if (a == ADDR_RT_STATUS) begin
      return 1'b1;
    end else if (a == ADDR_RT_CLEAR) begin
      return 1'b1;
    end else if (a == ADDR_IRQ_MASK) begin
      return 1'b1;
    end else if (a == ADDR_CONFIG) begin
      return 1'b1;
    end else if (a == ADDR_GK_PERIOD) begin
      return 1'b1;
    end else if (a == ADDR_RAW_DET) begin
      return 1'b1;
    end else if (a == ADDR_TX_ARM) begin
      return 1'b1;
    end else if (a == ADDR_SOFT_RST) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_mapped

  lsd_state_t state_reg; // Registered state
  lsd_state_t state_next; // Next state
  logic [1:0] rst_sync_reg; // Reset release synchroniser
  logic rst_b; // Synchronised reset

  // Release reset through two flip-flops; assertion stays asynchronous
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  // Combinational helpers
  logic setup_ph; // APB setup cycle
  logic access_ph; // APB access cycle, always completes
  logic wr_ok; // Completing write to a mapped address
  logic rd_ok; // Completing read of a mapped address
  logic fs_tick; // Frame sync rising edge
  logic ms_tick; // One millisecond elapsed
  logic sclk_rise; // Serial clock rising edge
  logic cs_rise; // Chip select returning high
  logic soft_rst; // Command or CS reset
  logic irq_clr; // Interrupt clearing event
  logic pend_kept; // Pending after clear
  logic tx_evt; // Armed transmit change
  logic [7:0] live; // Debounced status feeding the register
  logic [7:0] diff; // Unmasked bits differing from the register
  logic [NUM_CH-1:0] filt_in; // Second filter input per channel
  logic [7:0] rd_val; // Read data for the addressed register

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    setup_ph = I_PSEL & ~I_PENABLE;
    access_ph = I_PSEL & I_PENABLE;
    wr_ok = access_ph & I_PWRITE & addr_mapped(I_PADDR);
    rd_ok = access_ph & ~I_PWRITE & addr_mapped(I_PADDR);

    // Pins pass three stages; a level counts once stages two and three agree
    state_next.sync1 = {I_SCLK, I_CS_B, I_FS, I_GK_SAMPLE, I_AUX_DET,
                        I_LOOP_DET};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    for (int b = 0; b < NUM_PINS; b++) begin
      if (state_reg.sync2[b] == state_reg.sync3[b]) begin
        state_next.stab[b] = state_reg.sync3[b];
      end
    end

    // Timebase: the filters below depend on frame sync running, except an aux filter bypassed by period code zero
    fs_tick = state_next.stab[PIN_FS] & ~state_reg.stab[PIN_FS];
    ms_tick = 1'b0;
    if (fs_tick) begin
      if (state_reg.fs_div == 8'(FRAMES_PER_MS - 1)) begin
        state_next.fs_div = 8'h00;
        ms_tick = 1'b1;
      end else begin
        state_next.fs_div = state_reg.fs_div + 8'h01;
      end
    end

    // Per-channel filters
    for (int c = 0; c < NUM_CH; c++) begin
      // Loop filter: sample per frame, restart on change
      if (fs_tick) begin
        state_next.loop_smp[c] = state_reg.stab[PIN_LOOP + c];
        if (state_reg.stab[PIN_LOOP + c] != state_reg.loop_smp[c]) begin
          state_next.loop_cnt[c] = 4'h0;
        end else if (ms_tick && state_reg.loop_cnt[c] != 4'hF) begin
          state_next.loop_cnt[c] = state_reg.loop_cnt[c] + 4'h1;
        end
      end
      // Shared code against a private counter
      if (state_reg.loop_cnt[c] >= state_reg.loop_code) begin
        state_next.loop_stat[c] = state_reg.loop_smp[c];
      end

      // Second filter input follows the multiplex enable
      filt_in[c] = state_reg.mux_en ? state_reg.stab[PIN_GK + c]
                                    : state_reg.stab[PIN_AUX + c];
      if (state_reg.gk_code[c] == 4'h0) begin
        // No counter: input straight through
        state_next.aux_stat[c] = filt_in[c];
        state_next.gk_tmr[c] = 4'h0;
      end else if (ms_tick) begin
        if (state_reg.gk_tmr[c] + 4'h1 >= state_reg.gk_code[c]) begin
          state_next.gk_tmr[c] = 4'h0;
          if (filt_in[c] && state_reg.gk_cnt[c] != 3'(GK_MAX)) begin
            state_next.gk_cnt[c] = state_reg.gk_cnt[c] + 3'h1;
          end else if (!filt_in[c] && state_reg.gk_cnt[c] != 3'h0) begin
            state_next.gk_cnt[c] = state_reg.gk_cnt[c] - 3'h1;
          end
        end else begin
          state_next.gk_tmr[c] = state_reg.gk_tmr[c] + 4'h1;
        end
      end
      // Latch set at top, cleared at bottom, held between
      if (state_reg.gk_code[c] != 4'h0) begin
        if (state_reg.gk_cnt[c] == 3'(GK_MAX)) begin
          state_next.aux_stat[c] = 1'b1;
        end else if (state_reg.gk_cnt[c] == 3'h0) begin
          state_next.aux_stat[c] = 1'b0;
        end
      end
      live[2*c] = state_reg.loop_stat[c];
      live[2*c+1] = state_reg.aux_stat[c];
    end

    // Interrupt: freeze unmasked bits while pending, level until cleared
    irq_clr = (rd_ok & (I_PADDR == ADDR_RT_CLEAR))
            | (wr_ok & (I_PADDR == ADDR_IRQ_MASK));
    pend_kept = state_reg.pend & ~irq_clr;
    tx_evt = |(I_TX_CHANGE & state_reg.tx_arm);
    diff = (live ^ state_reg.rt) & ~state_reg.mask;
    if (pend_kept) begin
      // Masked bits keep tracking; unmasked ones stay frozen
      state_next.rt = (state_reg.rt & ~state_reg.mask)
                    | (live & state_reg.mask);
      state_next.pend = 1'b1;
    end else begin
      // A difference at the clear re-raises at once and relatches
      state_next.rt = live;
      state_next.pend = (|diff) | tx_evt;
    end

    // Long chip-select low counts serial clock edges
    sclk_rise = state_next.stab[PIN_SCLK] & ~state_reg.stab[PIN_SCLK];
    cs_rise = state_next.stab[PIN_CS] & ~state_reg.stab[PIN_CS];
    if (state_reg.stab[PIN_CS]) begin
      state_next.cs_cnt = 5'h00;
    end else if (sclk_rise && state_reg.cs_cnt != 5'(CS_RESET_EDGES)) begin
      state_next.cs_cnt = state_reg.cs_cnt + 5'h01;
    end
    soft_rst = (cs_rise && state_reg.cs_cnt == 5'(CS_RESET_EDGES))
             | (wr_ok & (I_PADDR == ADDR_SOFT_RST));

    // Register writes take effect in the access cycle
    if (wr_ok) begin
      if (I_PADDR == ADDR_IRQ_MASK) begin
        state_next.mask = I_PWDATA[7:0];
      end else if (I_PADDR == ADDR_CONFIG) begin
        state_next.loop_code = I_PWDATA[CFG_LOOP_LSB +: 4];
        state_next.open_drain = I_PWDATA[CFG_OPEN_DRAIN];
        state_next.mux_en = I_PWDATA[CFG_MUX_EN];
      end else if (I_PADDR == ADDR_GK_PERIOD) begin
        state_next.gk_code = I_PWDATA[4*NUM_CH-1:0];
      end else if (I_PADDR == ADDR_TX_ARM) begin
        state_next.tx_arm = I_PWDATA[NUM_CH-1:0];
      end
    end

    // Read mux, registered in the setup cycle so data comes from flops
    if (I_PADDR == ADDR_RT_STATUS || I_PADDR == ADDR_RT_CLEAR) begin
      rd_val = state_reg.rt;
    end else if (I_PADDR == ADDR_IRQ_MASK) begin
      rd_val = state_reg.mask;
    end else if (I_PADDR == ADDR_CONFIG) begin
      rd_val = {state_reg.mux_en, 2'b00, state_reg.open_drain,
                state_reg.loop_code};
    end else if (I_PADDR == ADDR_TX_ARM) begin
      rd_val = {4'h0, state_reg.tx_arm};
    end else begin
      rd_val = 8'h00;
    end
    if (setup_ph) begin
      state_next.pslverr = ~addr_mapped(I_PADDR);
      if (I_PADDR == ADDR_GK_PERIOD) begin
        state_next.prdata = {16'h0000, state_reg.gk_code};
      end else if (I_PADDR == ADDR_RAW_DET) begin
        // Raw synchronised levels, no debouncing
        state_next.prdata = {20'h0_0000, state_reg.stab[PIN_AUX +: 4],
                             state_reg.stab[PIN_GK +: 4],
                             state_reg.stab[PIN_LOOP +: 4]};
      end else begin
        state_next.prdata = {24'h00_0000, rd_val};
      end
    end

    // Command or CS reset restores every default except the synchroniser stages and stab
    if (soft_rst) begin
      state_next = reset_state();
      state_next.sync1 = state_reg.sync1;
      state_next.sync2 = state_reg.sync2;
      state_next.sync3 = state_reg.sync3;
      state_next.stab = state_reg.stab;
    end
  end

  // State register; reset loads a constant, CE low freezes everything
  always_ff @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= reset_state();
    end else if (I_CE) begin
      state_reg <= state_next;
    end
  end

  // APB answers without wait states
  assign O_PREADY = 1'b1;
  assign O_PRDATA = state_reg.prdata;
  assign O_PSLVERR = state_reg.pslverr & I_PSEL & I_PENABLE;

  // Open drain only pulls low; totem pole drives both levels
  assign O_IRQ_B_O = state_reg.open_drain ? 1'b0 : ~state_reg.pend;
  assign O_IRQ_B_OE = state_reg.open_drain ? state_reg.pend : 1'b1;
endmodule : lsd_top

//--- test/lsd_slic_model.sv
// Line interface side model: frame sync source and detect pin drivers
`timescale 1ns/1ps
module lsd_slic_model #(
  parameter int FS_CYC = 20 // Frame period in clocks, shortened
) (
  input wire logic i_clk, // Bench clock
  input wire logic [3:0] i_loop, // Requested loop-detect levels
  input wire logic [3:0] i_aux, // Requested aux detect levels
  input wire logic [3:0] i_gk, // Requested ground-key levels
  output logic o_fs, // Frame sync pin
  output logic [3:0] o_loop, // Loop-detect pins
  output logic [3:0] o_aux, // Aux detect pins
  output logic [3:0] o_gk // Ground-key sample pins
);
  int cnt = 0; // Position within the frame
  // Known pin levels from time zero
  initial begin
    o_fs = 1'b0;
    o_loop = 4'h0;
    o_aux = 4'h0;
    o_gk = 4'h0;
  end
  // Free-running frame sync, four clocks wide so the synchroniser sees it
  always @(posedge i_clk) begin
    cnt <= (cnt == FS_CYC - 1) ? 0 : cnt + 1;
    o_fs <= (cnt < 4);
  end
  // Detector outputs are driven levels, changed just after an edge
  always @(posedge i_clk) begin
    o_loop <= i_loop;
    o_aux <= i_aux;
    o_gk <= i_gk;
  end
endmodule : lsd_slic_model

//--- test/lsd_top_chk.sv
// Concurrent checks of the supervision block at its top-level ports
`timescale 1ns/1ps
module lsd_top_chk #(
  parameter int FRAMES_PER_MS = 8 // Frame ticks per ms
) (
  input wire logic I_CLK, // Clock
  input wire logic I_RST_B, // Reset, active low
  input wire logic I_CE, // Clock enable
  input wire logic [lsd_pkg::NUM_CH-1:0] I_TX_CHANGE, // Tx change pulses
  input wire logic I_PSEL, // APB select
  input wire logic I_PENABLE, // APB enable
  input wire logic I_PWRITE, // APB direction
  input wire logic [7:0] I_PADDR, // APB address
  input wire logic [31:0] I_PWDATA, // APB write data
  input wire logic [31:0] O_PRDATA, // APB read data
  input wire logic O_PSLVERR, // APB error
  input wire logic O_IRQ_B_O, // Interrupt level
  input wire logic O_IRQ_B_OE // Interrupt drive enable
);
  import lsd_pkg::*;
  typedef struct packed {logic [7:0] mask; logic [3:0] arm;} lsd_mir_t;
  lsd_mir_t mir_reg; // Mirror of mask and arm registers
  lsd_mir_t mir_next; // Next mirror value
  logic acc; // Completed APB access
  logic clr; // Access that clears a pending interrupt
  logic irq_low; // Interrupt line pulled low
  assign acc = I_PSEL && I_PENABLE && I_CE;
  assign clr = acc && (I_PWRITE ? (I_PADDR == ADDR_IRQ_MASK ||
    I_PADDR == ADDR_SOFT_RST) : I_PADDR == ADDR_RT_CLEAR);
  assign irq_low = O_IRQ_B_OE && !O_IRQ_B_O;
  // Mirror follows writes; soft reset reloads it at once, which only
  // makes the quiet check skip a cycle, never fire falsely
  always_comb begin
    mir_next = mir_reg;
    if (acc && I_PWRITE && I_PADDR == ADDR_IRQ_MASK) begin
      mir_next.mask = I_PWDATA[7:0];
    end
    if (acc && I_PWRITE && I_PADDR == ADDR_TX_ARM) begin
      mir_next.arm = I_PWDATA[3:0];
    end
    if (acc && I_PWRITE && I_PADDR == ADDR_SOFT_RST) begin
      mir_next = {RST_MASK, 4'h0};
    end
  end
  // Mirror register
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mir_reg <= {RST_MASK, 4'h0};
    end else begin
      mir_reg <= mir_next;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_srst;
    acc && I_PWRITE && I_PADDR == ADDR_SOFT_RST;
  endsequence
  sequence s_idle3;
    (!O_IRQ_B_OE && !O_IRQ_B_O) [*3];
  endsequence
  AST_DRIVE: assert property (O_IRQ_B_O |-> O_IRQ_B_OE)
    else $error("irq level high without drive");
  AST_HOLD: assert property (irq_low && !clr |=> irq_low)
    else $error("irq released without clear");
  AST_REL: assert property ($rose(I_RST_B) |-> (!O_IRQ_B_OE) [*3])
    else $error("irq driven after reset");
  AST_SRST: assert property (s_srst |-> ##2 s_idle3)
    else $error("soft reset left irq active");
  AST_RT_RD: assert property (acc && !I_PWRITE && (I_PADDR == ADDR_RT_STATUS
    || I_PADDR == ADDR_RT_CLEAR) |-> O_PRDATA[31:8] == '0 && !O_PSLVERR)
    else $error("status read wider than a byte");
  AST_MASK_RD: assert property (acc && !I_PWRITE && I_PADDR == ADDR_IRQ_MASK
    |-> O_PRDATA == {24'h00_0000, mir_reg.mask})
    else $error("mask readback wrong");
  AST_TX: assert property (I_CE && |(I_TX_CHANGE & mir_reg.arm) |=> irq_low)
    else $error("armed tx change gave no irq");
  AST_QUIET: assert property (!irq_low && mir_reg.mask == RST_MASK &&
    mir_reg.arm == 4'h0 |=> !irq_low)
    else $error("masked source raised irq");
endmodule : lsd_top_chk
bind lsd_top lsd_top_chk #(.FRAMES_PER_MS(FRAMES_PER_MS)) i_chk (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE),
  .I_TX_CHANGE(I_TX_CHANGE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .O_IRQ_B_O(O_IRQ_B_O),
  .O_IRQ_B_OE(O_IRQ_B_OE));

//--- test/lsd_top_tb_top.sv
// Self-checking bench of the supervision block
`timescale 1ns/1ps
module lsd_top_tb_top;
  import lsd_pkg::*;
  localparam int FPM = 2; // Frames per ms, shortened
  localparam int FS_CYC = 20; // Clocks per frame, shortened
  typedef struct {logic [7:0] a; logic [31:0] d, q; logic e;} lsd_row_t;
  // Register rows: address, write data, readback, error
  lsd_row_t rows [6] = '{
    '{ADDR_CONFIG, 32'h0000_0014, 32'h0000_0014, 1'b0},
    '{ADDR_GK_PERIOD, 32'h0000_0001, 32'h0000_0001, 1'b0},
    '{ADDR_TX_ARM, 32'h0000_000A, 32'h0000_000A, 1'b0},
    '{8'h20, 32'h0000_00FF, 32'h0000_0000, 1'b1},
    '{ADDR_IRQ_MASK, 32'h0000_005A, 32'h0000_005A, 1'b0},
    '{ADDR_IRQ_MASK, 32'h0000_00FF, 32'h0000_00FF, 1'b0}};
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq_o, irq_oe, fs, e;
  logic [3:0] loop_set = 4'h0, aux_set = 4'h0, gk_set = 4'h0, tx = 4'h0;
  logic [3:0] loop_pin, aux_pin, gk_pin;
  logic ce = 1'b1, cs_b = 1'b1, sclk = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  wire irq_n = irq_oe ? irq_o : 1'b1; // Pull-up holds the idle line high
  int bad_count = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  lsd_slic_model #(.FS_CYC(FS_CYC)) i_line (.i_clk(clk), .i_loop(loop_set),
    .i_aux(aux_set), .i_gk(gk_set), .o_fs(fs), .o_loop(loop_pin),
    .o_aux(aux_pin), .o_gk(gk_pin));
  // Chip select and serial clock idle until the long-select reset test
  lsd_top #(.FRAMES_PER_MS(FPM)) i_dut (.I_CLK(clk), .I_RST_B(rst_b),
    .I_CE(ce), .I_LOOP_DET(loop_pin), .I_AUX_DET(aux_pin),
    .I_GK_SAMPLE(gk_pin), .I_FS(fs), .I_CS_B(cs_b), .I_SCLK(sclk),
    .I_TX_CHANGE(tx), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_IRQ_B_O(irq_o), .O_IRQ_B_OE(irq_oe));
  task automatic results();
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] g, x);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      bad_count++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, r, x);
  endtask : rd
  // Level wait on the interrupt line, bounded
  task automatic wirq(input logic lvl, input string n);
    int k;
    k = 0;
    while (irq_n !== lvl && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk(n, 32'(irq_n), 32'(lvl));
    if (k >= 2000) results();
  endtask : wirq
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    tx <= v;
    @(posedge clk);
    tx <= 4'h0;
    step(3);
  endtask : pulse
  initial begin
    step(20);
    rst_b <= 1'b1;
    step(3);
    rd(ADDR_IRQ_MASK, 32'h0000_00FF, "mask reset");
    rd(ADDR_CONFIG, 32'h0000_0018, "config reset");
    rd(ADDR_RT_STATUS, 32'h0000_0000, "status reset");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk("write error", 32'(e), 32'(rows[i].e));
      rd(rows[i].a, rows[i].q, "readback");
      chk("read error", 32'(e), 32'(rows[i].e));
    end
    // Loop filter: shared 4 ms code, a two-frame dip restarts channel 0
    loop_set <= 4'b0101;
    step(100);
    rd(ADDR_RT_STATUS, 32'h0000_0000, "loop early");
    loop_set <= 4'b0100;
    step(40);
    loop_set <= 4'b0101;
    step(100);
    rd(ADDR_RT_STATUS, 32'h0000_0010, "loop restart");
    step(200);
    rd(ADDR_RT_STATUS, 32'h0000_0011, "loop settled");
    // Ground-key counter on the aux input of channel 0, 1 ms period
    aux_set <= 4'b0001;
    step(180);
    rd(ADDR_RT_STATUS, 32'h0000_0011, "gk five ticks");
    step(220);
    rd(ADDR_RT_STATUS, 32'h0000_0013, "gk set");
    aux_set <= 4'b0000;
    step(100);
    aux_set <= 4'b0001;
    rd(ADDR_RT_STATUS, 32'h0000_0013, "gk hold");
    step(400);
    aux_set <= 4'b0000;
    step(180);
    rd(ADDR_RT_STATUS, 32'h0000_0013, "gk saturated");
    step(140);
    rd(ADDR_RT_STATUS, 32'h0000_0011, "gk cleared");
    aux_set <= 4'b0010;
    step(10);
    rd(ADDR_RT_STATUS, 32'h0000_0019, "gk bypass");
    aux_set <= 4'b0000;
    gk_set <= 4'b0110;
    step(10);
    rd(ADDR_RAW_DET, 32'h0000_0065, "raw detect");
    gk_set <= 4'b0000;
    // Interrupt on channel 0 loop bit only
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_00FE);
    loop_set <= 4'b0100;
    wirq(1'b0, "irq raised");
    rd(ADDR_RT_STATUS, 32'h0000_0010, "status latched");
    loop_set <= 4'b0101;
    step(300);
    chk("irq held", 32'(irq_n), 32'h0000_0000);
    rd(ADDR_RT_STATUS, 32'h0000_0010, "status frozen");
    rd(ADDR_RT_CLEAR, 32'h0000_0010, "clearing read");
    step(2);
    chk("irq re-raised", 32'(irq_n), 32'h0000_0000);
    rd(ADDR_RT_STATUS, 32'h0000_0011, "status relatched");
    rd(ADDR_RT_CLEAR, 32'h0000_0011, "second clear");
    wirq(1'b1, "irq cleared");
    apb(1'b1, ADDR_TX_ARM, 32'h0000_0001);
    pulse(4'b0010);
    chk("tx unarmed", 32'(irq_n), 32'h0000_0001);
    pulse(4'b0001);
    chk("tx armed", 32'(irq_n), 32'h0000_0000);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_00FF);
    step(2);
    chk("mask write clear", 32'(irq_n), 32'h0000_0001);
    loop_set <= 4'b0100;
    step(300);
    chk("masked quiet", 32'(irq_n), 32'h0000_0001);
    rd(ADDR_RT_STATUS, 32'h0000_0010, "masked tracks");
    apb(1'b1, ADDR_CONFIG, 32'h0000_0004);
    step(2);
    chk("totem idle", 32'({irq_oe, irq_o}), 32'h0000_0003);
    // Mux enable routes the ground-key pin into the second filter
    gk_set <= 4'b0100;
    apb(1'b1, ADDR_CONFIG, 32'h0000_0084);
    step(10);
    rd(ADDR_RT_STATUS, 32'h0000_0030, "mux on");
    apb(1'b1, ADDR_CONFIG, 32'h0000_0004);
    step(10);
    rd(ADDR_RT_STATUS, 32'h0000_0010, "mux off");
    // Clock enable low: a loop change long past debounce must not land
    ce <= 1'b0;
    loop_set <= 4'b0000;
    step(300);
    ce <= 1'b1;
    rd(ADDR_RT_STATUS, 32'h0000_0010, "ce frozen");
    // Chip select low over seventeen serial clock rises, then high
    cs_b <= 1'b0;
    repeat (17) begin
      step(4);
      sclk <= 1'b1;
      step(4);
      sclk <= 1'b0;
    end
    step(4);
    cs_b <= 1'b1;
    step(8);
    rd(ADDR_CONFIG, 32'h0000_0018, "cs reset config");
    apb(1'b1, ADDR_CONFIG, 32'h0000_0004);
    apb(1'b1, ADDR_SOFT_RST, 32'h0000_0001);
    step(2);
    rd(ADDR_CONFIG, 32'h0000_0018, "soft reset config");
    rd(ADDR_IRQ_MASK, 32'h0000_00FF, "soft reset mask");
    results();
  end
endmodule : lsd_top_tb_top
